// ===== rtl/sysctl_cfg.svh
// Offsets, field positions, reset values and timing for the system control slice
`ifndef SYSCTL_CFG_SVH
`define SYSCTL_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_BROWNOUT_CONTROL 12'h030
`define OFS_REGULATOR_TRIM 12'h034
`define OFS_SOFT_RESET_CTRL_0 12'h040
`define OFS_SOFT_RESET_CTRL_1 12'h044
`define OFS_SOFT_RESET_CTRL_2 12'h048
`define OFS_RAW_EVENT_STATUS 12'h050
`define OFS_EVENT_MASK 12'h054
`define OFS_MASKED_STATUS 12'h058

// ****************************************
// Fields and reset values
// ****************************************
`define BO_NOISE_CHECK_BIT 0
`define BO_RESET_SELECT_BIT 1
`define BO_WAIT_LSB 2
`define BO_WAIT_MSB 15
`define BO_WAIT_RESET 14'h1FFF
`define BO_NOISE_CHECK_RESET 1'h1
`define BO_RESET_SELECT_RESET 1'h0
`define TRIM_WIDTH 6
`define TRIM_RESET 6'h00
`define SRC1_WRITABLE 32'h0303_0011
`define SRC2_WRITABLE 32'h0000_0007
`define EVENT_WIDTH 7
`define EV_PLL_FAULT 0
`define EV_BROWNOUT 1
`define EV_REG_UNREG 2
`define EV_MAIN_OSC 3
`define EV_BOOT_OSC 4
`define EV_CURRENT_LIMIT 5
`define EV_PLL_LOCK 6

// ****************************************
// Timing
// ****************************************
// Noise wait must exceed 500 us at 19.5 MHz boot oscillator: more than 9750 clocks
`define BO_PULSE_US 500
`define BO_OSC_MAX_KHZ 19500
`define BO_MIN_WAIT_COUNT ((`BO_PULSE_US * `BO_OSC_MAX_KHZ) / 1000)

`endif

// ===== rtl/sysctl_pkg.sv
// Types shared by the system control slice
package sysctl_pkg;

    typedef struct packed {
        logic [13:0] wait_count;
        logic reset_select;
        logic noise_check;
    } brownout_ctrl_t;

    typedef struct packed {
        logic pll_lock;
        logic current_limit;
        logic boot_osc_fault;
        logic main_osc_fault;
        logic regulator_unreg;
        logic brownout;
        logic pll_fault;
    } event_vec_t;

    typedef enum logic [1:0] {
        BO_IDLE,
        BO_WAIT,
        BO_HOLD
    } bo_state_t;

endpackage

// ===== rtl/sysctl_brownout_reset_irq.sv
// Brown-out response, regulator trim, software resets and system event status
// Notes on behaviour
// - Wait count in brown-out control bits 15:2, reset 0x1FFF boot-oscillator clocks.
// - Wait count field wide enough for over 10000 clocks.
// - With noise check set, brown-out waits programmed periods then resamples.
// - Still asserted after wait raises brown-out; deasserted suppresses everything.
// - Noise check clear: no resample, brown-out reported at once.
// - Select bit set routes brown-out to reset, clear routes to interrupt.
// - Six-bit regulator trim code selects output voltage; high codes reserved.
// - Soft reset bits change only where capability shows peripheral present.
// - Second reset register: comparators 25/24, timers 17/16, serial 4, 0.
// - Third reset register: GPIO C, B, A at bits 2, 1, 0.
// - Raw status bits ignore software writes and read zero after reset.
// - Raw bit 6 sets on PLL ready timer.
// - Raw bit 5 sets on regulator current limit.
// - Raw bit 4 on boot oscillator fault, bit 3 main oscillator.
// - Raw bit 2 sets when regulator is unregulated.
// - Raw bit 1 on brown-out; interrupt only if masked-in and select clear.
// - Raw bit 0 sets on PLL fault.
// - Mask register bits 6:0 read/write, reset 0, upper bits zero.
// - Interrupt raised when a raw bit and its mask are both set; bit 1 also needs select clear.
// - Writing 1 to masked status clears it and the raw bit.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "sysctl_cfg.svh"

module sysctl_brownout_reset_irq (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic boot_osc_clk,
    input wire logic brownout_detect,
    input wire logic pll_ready,
    input wire logic current_limit,
    input wire logic boot_osc_fault,
    input wire logic main_osc_fault,
    input wire logic regulator_unreg,
    input wire logic pll_fault,
    input wire logic [31:0] capability_mask_one,
    input wire logic [31:0] capability_mask_two,
    input wire logic [31:0] capability_mask_four,
    output logic [`TRIM_WIDTH-1:0] regulator_trim_code,
    output logic [31:0] periph_reset_0,
    output logic [31:0] periph_reset_1,
    output logic [31:0] periph_reset_2,
    output logic brownout_reset_req,
    output logic sys_irq
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Three stages; a change counts only once stages two and three agree
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic [NSYNC-1:0] s3_ff;
    logic [NSYNC-1:0] clean_ff;
    logic [NSYNC-1:0] clean_prev_ff;

    assign raw_in = {boot_osc_clk, pll_ready, current_limit, boot_osc_fault,
                     main_osc_fault, regulator_unreg, brownout_detect, pll_fault};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            clean_ff <= '0;
            clean_prev_ff <= '0;
        end else begin
            s1_ff <= raw_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    clean_ff[i] <= s3_ff[i];
                end
            end
            clean_prev_ff <= clean_ff;
        end
    end

    logic bo_level;
    logic bo_rise;
    logic osc_tick;
    logic [6:0] ev_rise;

    assign bo_level = clean_ff[1];
    assign bo_rise = clean_ff[1] & ~clean_prev_ff[1];
    assign osc_tick = clean_ff[7] & ~clean_prev_ff[7];
    assign ev_rise = clean_ff[6:0] & ~clean_prev_ff[6:0];

    // ****************************************
    // Register file
    // ****************************************
    sysctl_pkg::brownout_ctrl_t bo_ctrl_ff;
    logic [`TRIM_WIDTH-1:0] trim_ff;
    logic [31:0] src0_ff;
    logic [31:0] src1_ff;
    logic [31:0] src2_ff;
    logic [`EVENT_WIDTH-1:0] mask_ff;
    logic [`EVENT_WIDTH-1:0] raw_ff;
    logic [`EVENT_WIDTH-1:0] masked;

    logic wr_bo;
    logic wr_trim;
    logic wr_src0;
    logic wr_src1;
    logic wr_src2;
    logic wr_mask;
    logic wr_misc;

    assign wr_bo = wr_en && (addr == `OFS_BROWNOUT_CONTROL);
    assign wr_trim = wr_en && (addr == `OFS_REGULATOR_TRIM);
    assign wr_src0 = wr_en && (addr == `OFS_SOFT_RESET_CTRL_0);
    assign wr_src1 = wr_en && (addr == `OFS_SOFT_RESET_CTRL_1);
    assign wr_src2 = wr_en && (addr == `OFS_SOFT_RESET_CTRL_2);
    assign wr_mask = wr_en && (addr == `OFS_EVENT_MASK);
    assign wr_misc = wr_en && (addr == `OFS_MASKED_STATUS);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bo_ctrl_ff.wait_count <= `BO_WAIT_RESET;
            bo_ctrl_ff.reset_select <= `BO_RESET_SELECT_RESET;
            bo_ctrl_ff.noise_check <= `BO_NOISE_CHECK_RESET;
        end else if (wr_bo) begin
            bo_ctrl_ff.wait_count <= wdata[`BO_WAIT_MSB:`BO_WAIT_LSB];
            bo_ctrl_ff.reset_select <= wdata[`BO_RESET_SELECT_BIT];
            bo_ctrl_ff.noise_check <= wdata[`BO_NOISE_CHECK_BIT];
        end
    end

    // Reserved trim codes are stored as written; the regulator decides what they mean
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trim_ff <= `TRIM_RESET;
        end else if (wr_trim) begin
            trim_ff <= wdata[`TRIM_WIDTH-1:0];
        end
    end

    // Bits of absent peripherals keep their value, so they stay zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src0_ff <= '0;
            src1_ff <= '0;
            src2_ff <= '0;
        end else begin
            if (wr_src0) begin
                src0_ff <= (wdata & capability_mask_one) | (src0_ff & ~capability_mask_one);
            end
            if (wr_src1) begin
                src1_ff <= ((wdata & capability_mask_two) | (src1_ff & ~capability_mask_two))
                           & `SRC1_WRITABLE;
            end
            if (wr_src2) begin
                src2_ff <= ((wdata & capability_mask_four) | (src2_ff & ~capability_mask_four))
                           & `SRC2_WRITABLE;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= '0;
        end else if (wr_mask) begin
            mask_ff <= wdata[`EVENT_WIDTH-1:0];
        end
    end

    // ****************************************
    // Brown-out qualifier
    // ****************************************
    // Wait is counted in boot-oscillator edges seen through the synchroniser, so
    // the boot clock must be well below half the system clock
    sysctl_pkg::bo_state_t bo_state_ff;
    logic [13:0] bo_cnt_ff;
    logic bo_event;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bo_state_ff <= sysctl_pkg::BO_IDLE;
            bo_cnt_ff <= '0;
        end else begin
            case (bo_state_ff)
                sysctl_pkg::BO_IDLE: begin
                    if (bo_rise) begin
                        if (bo_ctrl_ff.noise_check) begin
                            bo_state_ff <= sysctl_pkg::BO_WAIT;
                            bo_cnt_ff <= bo_ctrl_ff.wait_count;
                        end else begin
                            bo_state_ff <= sysctl_pkg::BO_HOLD;
                        end
                    end
                end
                sysctl_pkg::BO_WAIT: begin
                    if (bo_cnt_ff == 14'h0000) begin
                        // Resample: low again means noise, drop the event
                        bo_state_ff <= bo_level ? sysctl_pkg::BO_HOLD
                                                : sysctl_pkg::BO_IDLE;
                    end else if (osc_tick) begin
                        bo_cnt_ff <= bo_cnt_ff - 14'h0001;
                    end
                end
                sysctl_pkg::BO_HOLD: begin
                    // Stay here until the supervisor releases, one event per assertion
                    if (!bo_level) begin
                        bo_state_ff <= sysctl_pkg::BO_IDLE;
                    end
                end
                default: begin
                    bo_state_ff <= sysctl_pkg::BO_IDLE;
                end
            endcase
        end
    end

    assign bo_event = (bo_state_ff == sysctl_pkg::BO_WAIT && bo_cnt_ff == 14'h0000 && bo_level)
                   || (bo_state_ff == sysctl_pkg::BO_IDLE && bo_rise
                       && !bo_ctrl_ff.noise_check);

    // ****************************************
    // Raw event status
    // ****************************************
    logic [`EVENT_WIDTH-1:0] ev_set;

    always_comb begin
        ev_set = '0;
        ev_set[`EV_PLL_LOCK] = ev_rise[6];
        ev_set[`EV_CURRENT_LIMIT] = ev_rise[5];
        ev_set[`EV_BOOT_OSC] = ev_rise[4];
        ev_set[`EV_MAIN_OSC] = ev_rise[3];
        ev_set[`EV_REG_UNREG] = ev_rise[2];
        ev_set[`EV_BROWNOUT] = bo_event;
        ev_set[`EV_PLL_FAULT] = ev_rise[0];
    end

    assign masked = raw_ff & mask_ff;

    // Set beats clear in the same cycle so no event is lost
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            raw_ff <= '0;
        end else begin
            for (int i = 0; i < `EVENT_WIDTH; i++) begin
                if (ev_set[i]) begin
                    raw_ff[i] <= 1'b1;
                end else if (wr_misc && wdata[i] && masked[i]) begin
                    raw_ff[i] <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic [`EVENT_WIDTH-1:0] irq_src;
    logic brq_ff;
    logic irq_ff;

    always_comb begin
        irq_src = masked;
        // Brown-out routed to reset never interrupts
        irq_src[`EV_BROWNOUT] = masked[`EV_BROWNOUT] & ~bo_ctrl_ff.reset_select;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            brq_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            brq_ff <= bo_event & bo_ctrl_ff.reset_select;
            irq_ff <= |irq_src;
        end
    end

    assign brownout_reset_req = brq_ff;
    assign sys_irq = irq_ff;
    assign regulator_trim_code = trim_ff;
    assign periph_reset_0 = src0_ff;
    assign periph_reset_1 = src1_ff;
    assign periph_reset_2 = src2_ff;

    // ****************************************
    // Read path
    // ****************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr == `OFS_BROWNOUT_CONTROL) begin
            rd_mux = {16'h0000, bo_ctrl_ff};
        end else if (addr == `OFS_REGULATOR_TRIM) begin
            rd_mux = {26'h0000000, trim_ff};
        end else if (addr == `OFS_SOFT_RESET_CTRL_0) begin
            rd_mux = src0_ff;
        end else if (addr == `OFS_SOFT_RESET_CTRL_1) begin
            rd_mux = src1_ff;
        end else if (addr == `OFS_SOFT_RESET_CTRL_2) begin
            rd_mux = src2_ff;
        end else if (addr == `OFS_RAW_EVENT_STATUS) begin
            rd_mux = {25'h0000000, raw_ff};
        end else if (addr == `OFS_EVENT_MASK) begin
            rd_mux = {25'h0000000, mask_ff};
        end else if (addr == `OFS_MASKED_STATUS) begin
            rd_mux = {25'h0000000, masked};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

// ===== tb/sysctl_supervisor_model.sv
// Model of the supervisors and oscillator detectors facing the slice
`timescale 1ns/100ps
module sysctl_supervisor_model (
    input wire sysctl_pkg::event_vec_t cmd,
    output logic boot_osc_clk,
    output sysctl_pkg::event_vec_t lines
);
    // Boot oscillator runs free near 15 MHz, well below the system clock so no edge is lost
    logic osc = 1'b0;
    always #33 osc = ~osc;
    assign boot_osc_clk = osc;
    // Detector outputs are plain levels, held as long as the bench asks
    assign lines = cmd;
endmodule

// ===== tb/sysctl_brownout_reset_irq_asserts.sv
// Concurrent checks on the ports of the system control slice
`timescale 1ns/100ps
`include "sysctl_cfg.svh"
module sysctl_brownout_reset_irq_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic brownout_detect,
    input wire logic [31:0] capability_mask_one,
    input wire logic [31:0] capability_mask_two,
    input wire logic [31:0] capability_mask_four,
    input wire logic [`TRIM_WIDTH-1:0] regulator_trim_code,
    input wire logic [31:0] periph_reset_0,
    input wire logic [31:0] periph_reset_1,
    input wire logic [31:0] periph_reset_2,
    input wire logic brownout_reset_req,
    input wire logic sys_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    read_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
        else $error("read data not zero outside a read");
    trim_write_a: assert property (wr_en && addr == 12'h034 |=>
        {26'h0, regulator_trim_code} == ($past(wdata) & 32'h3F)) else $error("trim not written");
    trim_hold_a: assert property (!(wr_en && addr == 12'h034) |=>
        $stable(regulator_trim_code)) else $error("trim changed without write");
    soft_zero_a: assert property (wr_en && addr == 12'h040 |=>
        periph_reset_0 == ($past(wdata) & $past(capability_mask_one))) else $error("reset 0 bad");
    soft_one_a: assert property (wr_en && addr == 12'h044 |=> periph_reset_1 ==
        ($past(wdata) & $past(capability_mask_two) & 32'h0303_0011)) else $error("reset 1 bad");
    soft_two_a: assert property (wr_en && addr == 12'h048 |=> periph_reset_2 ==
        ($past(wdata) & $past(capability_mask_four) & 32'h7)) else $error("reset 2 bad");
    pulse_once_a: assert property (brownout_reset_req |=> !brownout_reset_req)
        else $error("reset request longer than one cycle");
    // The filter keeps its level high only while one of these two pin samples is high
    pulse_cause_a: assert property (brownout_reset_req |->
        $past(brownout_detect, 4) || $past(brownout_detect, 5))
        else $error("reset request without brown-out");
    mask_off_a: assert property (wr_en && addr == 12'h054 && wdata[6:0] == 7'h00 |->
        ##[1:3] !sys_irq) else $error("interrupt stays with all masks off");
    mask_upper_a: assert property (rd_en && addr == 12'h054 |=> rdata[31:7] == 25'h0)
        else $error("mask upper bits not zero");
endmodule

bind sysctl_brownout_reset_irq sysctl_brownout_reset_irq_chk chk (.clock, .rst_n, .addr,
    .wdata, .wr_en, .rd_en, .rdata, .brownout_detect, .capability_mask_one,
    .capability_mask_two, .capability_mask_four, .regulator_trim_code, .periph_reset_0,
    .periph_reset_1, .periph_reset_2, .brownout_reset_req, .sys_irq);

// ===== tb/tb_top.sv
// Self-checking bench for the system control slice
`timescale 1ns/100ps
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata, pr0, pr1, pr2;
    logic [5:0] trim;
    logic boot_osc_clk, bo_req, irq;
    sysctl_pkg::event_vec_t cmd = '0;
    sysctl_pkg::event_vec_t lines;
    // Capabilities leave some peripherals absent so write gating shows
    logic [31:0] cap_one = 32'h0000_00F0;
    logic [31:0] cap_two = 32'h0301_0011;
    logic [31:0] cap_four = 32'h0000_0005;
    int n_fail = 0;
    int compares = 0;
    int i;

    always #2 clock = ~clock;

    sysctl_supervisor_model model (.cmd(cmd), .boot_osc_clk(boot_osc_clk), .lines(lines));

    sysctl_brownout_reset_irq dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .boot_osc_clk(boot_osc_clk),
        .brownout_detect(lines.brownout), .pll_ready(lines.pll_lock),
        .current_limit(lines.current_limit), .boot_osc_fault(lines.boot_osc_fault),
        .main_osc_fault(lines.main_osc_fault), .regulator_unreg(lines.regulator_unreg),
        .pll_fault(lines.pll_fault), .capability_mask_one(cap_one),
        .capability_mask_two(cap_two), .capability_mask_four(cap_four),
        .regulator_trim_code(trim), .periph_reset_0(pr0), .periph_reset_1(pr1),
        .periph_reset_2(pr2), .brownout_reset_req(bo_req), .sys_irq(irq));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic pulse(input int b, input int n);
        @(posedge clock);
        cmd[b] <= 1'b1;
        repeat (n) @(posedge clock);
        cmd[b] <= 1'b0;
    endtask

    // Bounded wait for the one-cycle reset request
    task automatic wait_req;
        compares++;
        for (int k = 0; k < 400; k++) begin
            @(posedge clock);
            #1;
            if (bo_req === 1'b1) return;
        end
        n_fail++;
        $display("BAD %0t no reset request", $time);
        summarize();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rchk(12'h030, 32'h0000_7FFD);
        rchk(12'h034, 32'h0);
        rchk(12'h040, 32'h0);
        rchk(12'h044, 32'h0);
        rchk(12'h048, 32'h0);
        rchk(12'h050, 32'h0);
        rchk(12'h054, 32'h0);
        rchk(12'h0FC, 32'h0);
    endtask

    task automatic t_regs;
        // Full wait field holds 16383, above the 9750 the pulse width needs
        wr(12'h030, 32'hFFFF_FFFE);
        rchk(12'h030, 32'h0000_FFFE);
        wr(12'h034, 32'h3F);
        rchk(12'h034, 32'h3F);
        wr(12'h034, 32'h1B);
        chk(32'(trim), 32'h1B);
        wr(12'h040, 32'hFFFF_FFFF);
        wr(12'h044, 32'hFFFF_FFFF);
        wr(12'h048, 32'hFFFF_FFFF);
        chk(pr0, 32'h0000_00F0);
        chk(pr1, 32'h0301_0011);
        chk(pr2, 32'h0000_0005);
        rchk(12'h044, 32'h0301_0011);
        wr(12'h044, 32'h0);
        chk(pr1, 32'h0);
        wr(12'h050, 32'h7F);
        rchk(12'h050, 32'h0);
        wr(12'h054, 32'hFFFF_FFFF);
        rchk(12'h054, 32'h7F);
        wr(12'h054, 32'h0);
    endtask

    task automatic t_events;
        for (i = 0; i < 7; i++) begin
            if (i == 1) continue;
            pulse(i, 8);
            idle(8);
            rchk(12'h050, 32'h1 << i);
            chk(32'(irq), 32'h0);
            wr(12'h054, 32'h1 << i);
            idle(3);
            chk(32'(irq), 32'h1);
            wr(12'h058, 32'h1 << i);
            idle(3);
            rchk(12'h050, 32'h0);
            chk(32'(irq), 32'h0);
            wr(12'h054, 32'h0);
        end
    endtask

    task automatic t_brownout;
        wr(12'h054, 32'h2);
        wr(12'h030, 32'h11);
        pulse(1, 8);
        idle(150);
        rchk(12'h050, 32'h0);
        pulse(1, 150);
        idle(10);
        rchk(12'h050, 32'h2);
        chk(32'(irq), 32'h1);
        wr(12'h058, 32'h2);
        wr(12'h030, 32'h13);
        @(posedge clock);
        cmd[1] <= 1'b1;
        wait_req();
        idle(4);
        chk(32'(irq), 32'h0);
        @(posedge clock);
        cmd[1] <= 1'b0;
        rchk(12'h050, 32'h2);
        wr(12'h058, 32'h2);
        wr(12'h030, 32'h10);
        pulse(1, 8);
        idle(8);
        rchk(12'h050, 32'h2);
    endtask

    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_events();
        t_brownout();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        chk(32'(trim), 32'h0);
        rchk(12'h030, 32'h0000_7FFD);
        summarize();
    end
endmodule
